//--- rtl/strap_loader_cfg.svh
// constants for the setting-pin loader and its phase gate control
`ifndef STRAP_LOADER_CFG_SVH
`define STRAP_LOADER_CFG_SVH

`define CLK_PERIOD_NS      40
`define REF_SETTLE_NS      10000
`define SEQ_LIMIT_US       500
`define ON_TIME_NS         200

`define STRAP_PINS         5
`define CODE_W             8
`define ADDR_W             8
`define PIN_CORE_FIRST     3'h0
`define PIN_CORE_SECOND    3'h1
`define PIN_SHARED         3'h2
`define PIN_GFX_FIRST      3'h3
`define PIN_LAST           3'h4

`define REG_CTRL           8'h00
`define REG_STATUS         8'h04
`define REG_CORE_CFG       8'h08
`define REG_GFX_CFG        8'h0C
`define REG_SHARED_CFG     8'h10

`define CTRL_DEM_BIT       0
`define CTRL_PH_LSB        1
`define CTRL_PH_MSB        2
`define CTRL_PH_RESET      2'h3
`define PH_ONE             2'h1

`define SH_GAIN_BIT        1
`define SH_BEH_BIT         2
`define SH_OVS_BIT         3
`define SH_ZLL_BIT         4
`define SH_ADDR_LSB        5
`define SH_ADDR_MSB        6
`define SH_PLATFORM_POWER_SENSE_BIT        1
`define SH_HFR_BIT         2
`define SH_SLEW_LSB        3
`define SH_SLEW_MSB        4
`define SH_COMP_BIT        5
`define SH_RRED_BIT        6

`endif

//--- rtl/strap_loader_pkg.sv
// types shared by the setting-pin loader and its phase gate control
`include "strap_loader_cfg.svh"
package strap_loader_pkg;

  typedef enum logic [5:0] {
    LD_IDLE   = 6'b00_0001,
    LD_REF    = 6'b00_0010,
    LD_F1     = 6'b00_0100,
    LD_F2_SET = 6'b00_1000,
    LD_F2     = 6'b01_0000,
    LD_DONE   = 6'b10_0000
  } ld_state_t;

  typedef struct packed {
    logic [`ADDR_W-1:0] addr;
    logic [31:0]        wdata;
    logic               wr;
    logic               rd;
  } bus_req_t;

  typedef struct packed {
    logic [`CODE_W-1:0] max_current_code;
    logic [3:0]         step_thr;
    logic [3:0]         oc_limit;
    logic [3:0]         step_width;
    logic [3:0]         ramp_amp;
    logic [3:0]         quick_thr;
    logic [3:0]         quick_width;
  } rail_cfg_t;

  typedef struct packed {
    logic [1:0] rail_addr;
    logic       zero_ll_en;
    logic       overshoot_guard_en;
    logic       overshoot_guard_beh;
    logic       gain_sel;
    logic       platform_power_sense_en;
    logic       hf_ramp_en;
    logic [1:0] step_slew;
    logic       step_comp_dis;
    logic       ramp_reduce;
  } shared_cfg_t;

  typedef struct packed {
    rail_cfg_t   core;
    rail_cfg_t   gfx;
    shared_cfg_t shared;
  } strap_cfg_t;

  typedef struct packed {
    logic [1:0]                           prdy_sync;
    logic                                 prdy_prev;
    ld_state_t                            st;
    logic [15:0]                          tmo;
    logic [15:0]                          wait_cnt;
    logic [2:0]                           pin;
    logic                                 ref_high;
    logic [`STRAP_PINS-1:0]               isrc_en;
    logic                                 adc_start;
    logic [2:0]                           adc_sel;
    logic [2*`STRAP_PINS-1:0][`CODE_W-1:0] raw;
    strap_cfg_t                           cfg;
    logic                                 done;
    logic                                 timeout;
    logic                                 dem_en;
    logic [1:0]                           core_phases;
    logic [31:0]                          rdata;
  } ld_reg_t;

  typedef struct packed {
    logic [1:0] fb_sync;
    logic       fb_prev;
    logic [2:0] neg_sync1;
    logic [2:0] neg_sync2;
    logic [1:0] ptr;
    logic [2:0] on_busy;
    logic [2:0][7:0] on_cnt;
    logic [2:0] high_side_gate;
    logic [2:0] low_side_gate;
  } pg_reg_t;

endpackage : strap_loader_pkg

//--- rtl/phase_gate_ctrl.sv
// fixed on-time pulses with round-robin phase interleave and diode emulation gating
`timescale 1ns/1ps
`include "strap_loader_cfg.svh"
module phase_gate_ctrl
  import strap_loader_pkg::*;
#(
  parameter int ON_CYC = (`ON_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS
) (
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       nrst,
  // comparator and phase sense pins
  input  wire logic       fb_at_comp,
  input  wire logic [2:0] phase_node_neg,
  // mode
  input  wire logic       dem_en,
  input  wire logic [1:0] phase_count,
  // gates
  output logic      [2:0] high_side_gate,
  output logic      [2:0] low_side_gate
);

  pg_reg_t r_q;
  pg_reg_t r_d;
  logic    trip;

  always_comb begin
    r_d = r_q;
    r_d.fb_sync   = {r_q.fb_sync[0], fb_at_comp};
    r_d.fb_prev   = r_q.fb_sync[1];
    r_d.neg_sync1 = phase_node_neg;
    r_d.neg_sync2 = r_q.neg_sync1;
    trip = r_q.fb_sync[1] & ~r_q.fb_prev;
    for (int i = 0; i < 3; i++) begin
      if (r_q.on_busy[i]) begin
        if (r_q.on_cnt[i] == 8'(ON_CYC - 1)) begin
          r_d.on_busy[i] = 1'b0;
        end else begin
          r_d.on_cnt[i] = r_q.on_cnt[i] + 8'h01;
        end
      end
    end
    if (trip) begin
      r_d.on_busy[r_q.ptr] = 1'b1;
      r_d.on_cnt[r_q.ptr]  = 8'h00;
      // a zero phase count keeps the pointer inside the three phases
      if (phase_count == 2'h0 || r_q.ptr >= phase_count - 2'h1) begin
        r_d.ptr = 2'h0;
      end else begin
        r_d.ptr = r_q.ptr + 2'h1;
      end
    end
    for (int i = 0; i < 3; i++) begin
      r_d.high_side_gate[i] = r_d.on_busy[i] && (2'(i) < phase_count);
      if (r_d.high_side_gate[i] || 2'(i) >= phase_count) begin
        r_d.low_side_gate[i] = 1'b0;
      end else if (dem_en) begin
        r_d.low_side_gate[i] = r_q.neg_sync2[i];
      end else begin
        r_d.low_side_gate[i] = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      r_q <= '0;
    end else begin
      r_q <= r_d;
    end
  end

  assign high_side_gate = r_q.high_side_gate;
  assign low_side_gate  = r_q.low_side_gate;

endmodule : phase_gate_ctrl

//--- rtl/pin_strap_setting_loader.sv
// power-up setting-pin measurement, decode and latch, with core phase gate control
//
// Our own choices: strobed register access and the register addresses.
`timescale 1ns/1ps
`include "strap_loader_cfg.svh"
module pin_strap_setting_loader
  import strap_loader_pkg::*;
#(
  parameter int TIMEOUT_CYC = `SEQ_LIMIT_US * 1000 / `CLK_PERIOD_NS,
  parameter int SETTLE_CYC  = (`REF_SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS
) (
  // clock and reset
  input  wire logic                   clk_sys,
  input  wire logic                   nrst,
  // register port
  input  wire bus_req_t               bus_req,
  output logic [31:0]                 rd_data,
  // power ready pin
  input  wire logic                   power_ready,
  // setting converter
  output logic                        adc_start,
  output logic [2:0]                  adc_sel,
  input  wire logic                   adc_valid,
  input  wire logic [`CODE_W-1:0]     adc_code,
  output logic [`STRAP_PINS-1:0]      isrc_en,
  output logic                        ref_high,
  // decoded settings
  output strap_cfg_t                  strap_cfg,
  output logic                        setting_done,
  // phase gate pins
  input  wire logic                   fb_at_comp,
  input  wire logic [2:0]             phase_node_neg,
  output logic [2:0]                  high_side_gate,
  output logic [2:0]                  low_side_gate
);

  ld_reg_t r_q;
  ld_reg_t r_d;
  logic    prdy_rise;
  logic    settled;
  logic    expired;

  // splits a code into two four-bit fields, upper first
  function automatic logic [7:0] nibbles(input logic [`CODE_W-1:0] code);
    nibbles = code[7:0];
  endfunction : nibbles

  function automatic rail_cfg_t decode_rail(input logic [`CODE_W-1:0] f1a,
                                            input logic [`CODE_W-1:0] f2a,
                                            input logic [`CODE_W-1:0] f1b,
                                            input logic [`CODE_W-1:0] f2b);
    rail_cfg_t c;
    c.max_current_code = f1a;
    {c.step_thr, c.oc_limit}      = nibbles(f2a);
    {c.step_width, c.ramp_amp}    = nibbles(f1b);
    {c.quick_thr, c.quick_width}  = nibbles(f2b);
    decode_rail = c;
  endfunction : decode_rail

  function automatic strap_cfg_t decode_all(
      input logic [2*`STRAP_PINS-1:0][`CODE_W-1:0] raw,
      input logic [1:0]                            phases);
    strap_cfg_t c;
    logic [`CODE_W-1:0] s1;
    logic [`CODE_W-1:0] s2;
    s1 = raw[2*`PIN_SHARED];
    s2 = raw[2*`PIN_SHARED+1];
    c.core = decode_rail(raw[2*`PIN_CORE_FIRST], raw[2*`PIN_CORE_FIRST+1],
                         raw[2*`PIN_CORE_SECOND], raw[2*`PIN_CORE_SECOND+1]);
    c.gfx  = decode_rail(raw[2*`PIN_GFX_FIRST], raw[2*`PIN_GFX_FIRST+1],
                         raw[2*`PIN_LAST], raw[2*`PIN_LAST+1]);
    // shared pin uses 25 mV bands, two converter codes each
    c.shared.gain_sel                = s1[`SH_GAIN_BIT];
    c.shared.overshoot_guard_beh     = s1[`SH_BEH_BIT];
    c.shared.overshoot_guard_en      = s1[`SH_OVS_BIT];
    c.shared.zero_ll_en              = s1[`SH_ZLL_BIT];
    c.shared.rail_addr               = s1[`SH_ADDR_MSB:`SH_ADDR_LSB];
    c.shared.platform_power_sense_en = s2[`SH_PLATFORM_POWER_SENSE_BIT];
    c.shared.hf_ramp_en              = s2[`SH_HFR_BIT];
    c.shared.step_slew               = s2[`SH_SLEW_MSB:`SH_SLEW_LSB];
    c.shared.step_comp_dis           = s2[`SH_COMP_BIT];
    c.shared.ramp_reduce             = s2[`SH_RRED_BIT] && (phases == `PH_ONE);
    decode_all = c;
  endfunction : decode_all

  always_comb begin
    r_d = r_q;
    r_d.prdy_sync = {r_q.prdy_sync[0], power_ready};
    r_d.prdy_prev = r_q.prdy_sync[1];
    r_d.adc_start = 1'b0;
    r_d.rdata     = 32'h0000_0000;
    prdy_rise = r_q.prdy_sync[1] & ~r_q.prdy_prev;
    settled   = (r_q.wait_cnt == 16'(SETTLE_CYC - 1));
    // only a running sequence expires; a count left by a cut run must not end the next one
    expired   = (r_q.tmo == 16'(TIMEOUT_CYC - 1)) && (r_q.st != LD_IDLE)
                && (r_q.st != LD_DONE);
    if (!r_q.st[0] && !r_q.st[5]) begin
      r_d.tmo = r_q.tmo + 16'h0001;
    end

    unique case (r_q.st)
      LD_IDLE, LD_DONE: begin
        if (prdy_rise) begin
          r_d.ref_high = 1'b1;
          r_d.tmo      = 16'h0000;
          r_d.wait_cnt = 16'h0000;
          r_d.pin      = 3'h0;
          r_d.done     = 1'b0;
          r_d.timeout  = 1'b0;
          r_d.st       = LD_REF;
        end
      end
      LD_REF: begin
        r_d.wait_cnt = r_q.wait_cnt + 16'h0001;
        if (settled) begin
          r_d.adc_start = 1'b1;
          r_d.adc_sel   = r_q.pin;
          r_d.st        = LD_F1;
        end
      end
      LD_F1: begin
        if (adc_valid) begin
          r_d.raw[{r_q.pin, 1'b0}] = adc_code;
          r_d.isrc_en[r_q.pin]     = 1'b1;
          r_d.wait_cnt             = 16'h0000;
          r_d.st                   = LD_F2_SET;
        end
      end
      LD_F2_SET: begin
        r_d.wait_cnt = r_q.wait_cnt + 16'h0001;
        if (settled) begin
          r_d.adc_start = 1'b1;
          r_d.adc_sel   = r_q.pin;
          r_d.st        = LD_F2;
        end
      end
      LD_F2: begin
        if (adc_valid) begin
          r_d.raw[{r_q.pin, 1'b1}] = adc_code;
          r_d.isrc_en              = '0;
          r_d.wait_cnt             = 16'h0000;
          if (r_q.pin == `PIN_LAST) begin
            r_d.st = LD_DONE;
          end else begin
            r_d.pin = r_q.pin + 3'h1;
            r_d.st  = LD_REF;
          end
        end
      end
      default: begin
        r_d.st = LD_IDLE;
      end
    endcase

    // a stuck converter cannot hold the reference high past the limit
    if (expired && r_d.st != LD_DONE) begin
      r_d.st      = LD_DONE;
      r_d.timeout = 1'b1;
      r_d.isrc_en = '0;
    end
    if (r_d.st == LD_DONE && r_q.st != LD_DONE) begin
      r_d.ref_high = 1'b0;
      r_d.done     = 1'b1;
      r_d.cfg      = decode_all(r_d.raw, r_q.core_phases);
    end

    if (bus_req.wr && bus_req.addr == `REG_CTRL) begin
      r_d.dem_en      = bus_req.wdata[`CTRL_DEM_BIT];
      r_d.core_phases = bus_req.wdata[`CTRL_PH_MSB:`CTRL_PH_LSB];
    end
    if (bus_req.rd) begin
      unique case (bus_req.addr)
        `REG_CTRL:       r_d.rdata = {29'h0, r_q.core_phases, r_q.dem_en};
        `REG_STATUS:     r_d.rdata = {26'h0, r_q.st};
        `REG_CORE_CFG:   r_d.rdata = r_q.cfg.core;
        `REG_GFX_CFG:    r_d.rdata = r_q.cfg.gfx;
        `REG_SHARED_CFG: r_d.rdata = {17'h0, r_q.timeout, r_q.done,
                                      r_q.ref_high, r_q.cfg.shared};
        default:         r_d.rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      r_q             <= '0;
      r_q.st          <= LD_IDLE;
      r_q.core_phases <= `CTRL_PH_RESET;
    end else begin
      r_q <= r_d;
    end
  end

  assign rd_data      = r_q.rdata;
  assign adc_start    = r_q.adc_start;
  assign adc_sel      = r_q.adc_sel;
  assign isrc_en      = r_q.isrc_en;
  assign ref_high     = r_q.ref_high;
  assign strap_cfg    = r_q.cfg;
  assign setting_done = r_q.done;

  phase_gate_ctrl u_phase_gate (
    .clk_sys        (clk_sys),
    .nrst           (nrst),
    .fb_at_comp     (fb_at_comp),
    .phase_node_neg (phase_node_neg),
    .dem_en         (r_q.dem_en),
    .phase_count    (r_q.core_phases),
    .high_side_gate (high_side_gate),
    .low_side_gate  (low_side_gate)
  );

endmodule : pin_strap_setting_loader

//--- sim/strap_loader_props.sv
// port-level assertion checker for the setting-pin loader
`timescale 1ns/1ps
`include "strap_loader_cfg.svh"
module strap_loader_props
  import strap_loader_pkg::*;
#(
  parameter int TIMEOUT_CYC = 12500,
  parameter int SETTLE_CYC  = 250
) (
  // clock and reset
  input wire logic                   clk_sys,
  input wire logic                   nrst,
  // loader
  input wire logic                   power_ready,
  input wire logic                   adc_start,
  input wire logic [2:0]             adc_sel,
  input wire logic                   adc_valid,
  input wire logic [`STRAP_PINS-1:0] isrc_en,
  input wire logic                   ref_high,
  input wire strap_cfg_t             strap_cfg,
  input wire logic                   setting_done,
  // gates
  input wire logic [2:0]             high_side_gate,
  input wire logic [2:0]             low_side_gate
);
  logic [15:0] run_q;
  logic [15:0] gap_q;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  // cycles at the high reference, and since the last conversion answer
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      run_q <= 16'h0000;
      gap_q <= 16'h0000;
    end else begin
      run_q <= ref_high ? run_q + 16'h0001 : 16'h0000;
      gap_q <= (adc_valid || !ref_high) ? 16'h0000 : gap_q + 16'h0001;
    end
  end
  ref_rise_a: assert property ($rose(power_ready) |-> ##[1:4] ref_high)
    else $error("reference not raised after power ready");
  settle_gap_a: assert property (adc_start |-> gap_q >= 16'(SETTLE_CYC - 2)
    && gap_q <= 16'(SETTLE_CYC + 1)) else $error("conversion started off the settle time");
  start_pulse_a: assert property (adc_start |=> !adc_start)
    else $error("conversion start longer than one cycle");
  isrc_one_a: assert property (|isrc_en |-> ref_high && isrc_en == (5'h01 << adc_sel))
    else $error("current source on the wrong pin");
  seq_bound_a: assert property (ref_high |-> run_q <= 16'(TIMEOUT_CYC + 4))
    else $error("setting sequence overran its bound");
  ref_drop_a: assert property ($fell(ref_high) |-> setting_done)
    else $error("reference lowered before the sequence ended");
  cfg_hold_a: assert property (setting_done && !ref_high && $past(setting_done)
    && !$past(ref_high) |-> $stable(strap_cfg)) else $error("latched settings changed");
  hs_width_a: assert property ($rose(high_side_gate[0])
    |-> high_side_gate[0] [*5] ##1 !high_side_gate[0]) else $error("on-time width wrong");
  gate_excl_a: assert property ((high_side_gate & low_side_gate) == 3'h0)
    else $error("both gates of a phase on");
endmodule : strap_loader_props

bind pin_strap_setting_loader strap_loader_props #(
  .TIMEOUT_CYC(TIMEOUT_CYC),
  .SETTLE_CYC (SETTLE_CYC)
) i_strap_loader_props (
  .clk_sys, .nrst, .power_ready, .adc_start, .adc_sel, .adc_valid, .isrc_en, .ref_high,
  .strap_cfg, .setting_done, .high_side_gate, .low_side_gate
);

//--- sim/strap_net_model.sv
// divider networks and setting converter on the loader's far side
`timescale 1ns/1ps
`include "strap_loader_cfg.svh"
module strap_net_model (
  // clock and reset
  input  wire logic                   clk_sys,
  input  wire logic                   nrst,
  // converter request
  input  wire logic                   adc_start,
  input  wire logic [2:0]             adc_sel,
  input  wire logic [`STRAP_PINS-1:0] isrc_en,
  input  wire logic                   ref_high,
  // pin voltages in millivolts and answer control
  input  wire logic [4:0][11:0]       f1_mv,
  input  wire logic [4:0][11:0]       f2_mv,
  input  wire logic                   slow,
  input  wire logic                   mute,
  // converter answer
  output logic                        adc_valid,
  output logic [`CODE_W-1:0]          adc_code
);
  logic [5:0]         cnt_q;
  logic [`CODE_W-1:0] last_q;
  logic [11:0]        pin_mv;
  // divider needs the high reference; the current source gives function two
  always_comb begin
    pin_mv = ref_high ? f1_mv[adc_sel] : 12'h000;
    if (isrc_en[adc_sel]) begin
      pin_mv = f2_mv[adc_sel];
    end
  end
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      cnt_q     <= 6'h00;
      adc_valid <= 1'b0;
      last_q    <= 8'h00;
    end else begin
      adc_valid <= 1'b0;
      if (adc_start && !mute) begin
        cnt_q <= slow ? 6'h14 : 6'h02;
      end else if (cnt_q != 6'h00) begin
        cnt_q <= cnt_q - 6'h01;
        if (cnt_q == 6'h01) begin
          adc_valid <= 1'b1;
          last_q    <= 8'(32'(pin_mv) * 256 / 3200);
        end
      end
    end
  end
  // code lines carry the inverted last code between answers
  assign adc_code = adc_valid ? last_q : ~last_q;
endmodule : strap_net_model

//--- sim/tb_pin_strap_setting_loader.sv
// self-checking bench for the setting-pin loader
`timescale 1ns/1ps
`include "strap_loader_cfg.svh"
`define CHK(g, x) begin n_compared++; if ((g) !== (x)) begin n_fail++; \
  $display("ERROR t=%0t got %h exp %h", $time, g, x); end end
module tb_pin_strap_setting_loader import strap_loader_pkg::*;;
  logic             clk_sys, nrst, power_ready, fb_at_comp, slow, mute;
  logic             adc_start, adc_valid, ref_high, setting_done;
  logic [2:0]       phase_node_neg, adc_sel, high_side_gate, low_side_gate;
  logic [4:0]       isrc_en;
  logic [7:0]       adc_code;
  logic [31:0]      rd_data, rv;
  logic [4:0][11:0] f1_mv, f2_mv;
  bus_req_t         bus_req;
  strap_cfg_t       strap_cfg;
  int               n_fail, n_compared, cyc;

  pin_strap_setting_loader #(.TIMEOUT_CYC(2000), .SETTLE_CYC(4)) i_pin_strap_setting_loader (
    .clk_sys, .nrst, .bus_req, .rd_data, .power_ready, .adc_start, .adc_sel, .adc_valid,
    .adc_code, .isrc_en, .ref_high, .strap_cfg, .setting_done, .fb_at_comp, .phase_node_neg,
    .high_side_gate, .low_side_gate);
  strap_net_model i_strap_net_model (
    .clk_sys, .nrst, .adc_start, .adc_sel, .isrc_en, .ref_high, .f1_mv, .f2_mv, .slow, .mute,
    .adc_valid, .adc_code);

  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      give_verdict();
    end
  end

  function automatic logic [7:0] e(input logic [11:0] mv);
    return 8'(32'(mv) * 256 / 3200);
  endfunction : e

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys);
    bus_req <= '0;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(posedge clk_sys);
    bus_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys);
    bus_req <= '0;
    @(negedge clk_sys);
    rv = rd_data;
  endtask : rd

  task automatic pr_cycle(input int lim);
    @(posedge clk_sys);
    power_ready <= 1'b0;
    repeat (4) @(posedge clk_sys);
    power_ready <= 1'b1;
    repeat (4) @(posedge clk_sys);
    @(negedge clk_sys);
    `CHK(ref_high, 1'b1)
    for (int i = 0; i < lim && !setting_done; i++) @(negedge clk_sys);
    `CHK(setting_done, 1'b1)
    `CHK(ref_high, 1'b0)
  endtask : pr_cycle

  task automatic chk_cfg(input logic rr);
    logic [7:0] a, b;
    a = e(f1_mv[2]);
    b = e(f2_mv[2]);
    `CHK(strap_cfg.core, {e(f1_mv[0]), e(f2_mv[0]), e(f1_mv[1]), e(f2_mv[1])})
    `CHK(strap_cfg.gfx, {e(f1_mv[3]), e(f2_mv[3]), e(f1_mv[4]), e(f2_mv[4])})
    `CHK(strap_cfg.shared, {a[6:1], b[1], b[2], b[4:3], b[5], b[6] & rr})
  endtask : chk_cfg

  task automatic trip(input logic [2:0] exp);
    @(posedge clk_sys);
    fb_at_comp <= 1'b1;
    repeat (2) @(posedge clk_sys);
    fb_at_comp <= 1'b0;
    @(negedge clk_sys);
    for (int i = 0; i < 8 && high_side_gate == 3'h0; i++) @(negedge clk_sys);
    `CHK(high_side_gate, exp)
    repeat (8) @(negedge clk_sys);
  endtask : trip

  task automatic t_regs();
    rd(`REG_CTRL);
    `CHK(rv, 32'h0000_0006)
    wr(`REG_STATUS, 32'hFFFF_FFFF);
    rd(`REG_STATUS);
    `CHK(rv, 32'h0000_0001)
    rd(8'h20);
    `CHK(rv, 32'h0000_0000)
    wr(`REG_CTRL, 32'h0000_0004);
    rd(`REG_CTRL);
    `CHK(rv, 32'h0000_0004)
    $display("register test done");
  endtask : t_regs

  task automatic t_load();
    wr(`REG_CTRL, 32'h0000_0006);
    pr_cycle(600);
    chk_cfg(1'b0);
    `CHK(strap_cfg.core.max_current_code, 8'h40)
    $display("load test done");
  endtask : t_load

  task automatic t_hold();
    @(posedge clk_sys);
    f1_mv[0] <= 12'h194;
    repeat (50) @(negedge clk_sys);
    `CHK(strap_cfg.core.max_current_code, 8'h40)
    wr(`REG_CTRL, 32'h0000_0002);
    slow <= 1'b1;
    pr_cycle(1500);
    chk_cfg(1'b1);
    `CHK(strap_cfg.core.max_current_code, 8'h20)
    $display("relatch test done");
  endtask : t_hold

  task automatic t_timeout();
    @(posedge clk_sys);
    mute <= 1'b1;
    pr_cycle(2300);
    rd(`REG_SHARED_CFG);
    `CHK(rv[14:12], 3'b110)
    @(posedge clk_sys);
    mute <= 1'b0;
    pr_cycle(600);
    rd(`REG_SHARED_CFG);
    `CHK(rv[14:12], 3'b010)
    chk_cfg(1'b1);
    $display("timeout test done");
  endtask : t_timeout

  task automatic t_gates();
    wr(`REG_CTRL, 32'h0000_0006);
    for (int k = 0; k < 6; k++) trip(3'h1 << (k % 3));
    wr(`REG_CTRL, 32'h0000_0004);
    for (int k = 0; k < 4; k++) trip(3'h1 << (k % 2));
    wr(`REG_CTRL, 32'h0000_0003);
    @(posedge clk_sys);
    phase_node_neg <= 3'h1;
    repeat (4) @(negedge clk_sys);
    `CHK(low_side_gate, 3'h1)
    @(posedge clk_sys);
    phase_node_neg <= 3'h0;
    repeat (4) @(negedge clk_sys);
    `CHK(low_side_gate, 3'h0)
    $display("gate test done");
  endtask : t_gates

  task automatic give_verdict();
    $display("compared %0d mismatched %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : give_verdict

  initial begin
    nrst = 1'b0;
    power_ready = 1'b0;
    fb_at_comp = 1'b0;
    phase_node_neg = 3'h0;
    slow = 1'b0;
    mute = 1'b0;
    bus_req = '0;
    f1_mv = {12'h7D0, 12'h3E8, 12'h465, 12'h5DC, 12'h324};
    f2_mv = {12'h992, 12'h23F, 12'h52D, 12'h753, 12'h2EE};
    repeat (4) @(posedge clk_sys);
    nrst <= 1'b1;
    t_regs();
    t_load();
    t_hold();
    t_timeout();
    t_gates();
    give_verdict();
  end
endmodule : tb_pin_strap_setting_loader
